/* rtl/tco_defines.svh */
`ifndef TCO_DEFINES_SVH
`define TCO_DEFINES_SVH

// Byte addresses of the register words.
`define TCO_OFS_CTRL_A 8'h80
`define TCO_OFS_CTRL_B 8'h84
`define TCO_OFS_CMP_A 8'h88
`define TCO_OFS_CMP_B 8'h8C
`define TCO_OFS_CAPTURE 8'h90
`define TCO_OFS_COUNT 8'h94
`define TCO_OFS_STATUS 8'h98

// Field positions in the first control register.
`define TCO_CHA_MODE_HI 7
`define TCO_CHA_MODE_LO 6
`define TCO_CHB_MODE_HI 5
`define TCO_CHB_MODE_LO 4
`define TCO_WGM_LOW_HI 1
`define TCO_WGM_LOW_LO 0
// Field positions in the second control register.
`define TCO_WGM_HIGH_HI 4
`define TCO_WGM_HIGH_LO 3
`define TCO_CLKSEL_HI 2
`define TCO_CLKSEL_LO 0
// Status flag positions.
`define TCO_FLAG_MATCH_A 0
`define TCO_FLAG_MATCH_B 1
`define TCO_FLAG_OVF 2

// Reset values.
`define TCO_RST_CTRL 8'h00
`define TCO_RST_WORD16 16'h0000

// Fixed counter limits.
`define TCO_MAX 16'hFFFF
`define TCO_BOTTOM 16'h0000
`define TCO_TOP8 16'h00FF
`define TCO_TOP9 16'h01FF
`define TCO_TOP10 16'h03FF

`endif

/* rtl/tco_pkg.sv */
package tco_pkg;
   // Broad class of the selected waveform mode.
   typedef enum logic [1:0] {
      TCO_NON_PWM = 2'h0,
      TCO_FAST_PWM = 2'h1,
      TCO_DUAL_PWM = 2'h2
   } tco_class_e;
   // Four-bit waveform-generation mode.
   typedef logic [3:0] tco_wgm_t;
   // Two-bit output-mode field of one channel.
   typedef logic [1:0] tco_om_t;
endpackage

/* rtl/tco_top.sv */
`timescale 1ns/1ps
`include "tco_defines.svh"
`default_nettype none

module tco_top
   import tco_pkg::*;
(
   input wire logic sys_clk, // 40 MHz system clock.
   input wire logic nrst, // Synchronous reset, active low.
   input wire logic [7:0] avs_address, // Byte address.
   input wire logic avs_read, // Read request.
   input wire logic avs_write, // Write request.
   input wire logic [31:0] avs_writedata, // Write data.
   output logic [31:0] avs_readdata, // Read data.
   output logic avs_waitrequest, // Stall, high until answered.
   input wire logic port_data_a, // Normal port value for pin A.
   input wire logic port_dir_a, // Direction bit of pin A.
   input wire logic port_data_b, // Normal port value for pin B.
   input wire logic port_dir_b, // Direction bit of pin B.
   output logic compare_out_a, // Level driven on pin A.
   output logic compare_out_a_oe, // Pin A driver enable.
   output logic compare_out_b, // Level driven on pin B.
   output logic compare_out_b_oe // Pin B driver enable.
);

   logic [7:0] ctrl_a; // First control register.
   logic [4:0] ctrl_b; // Upper mode bits and clock select.
   logic [15:0] buf_a; // Buffer copy of compare A.
   logic [15:0] buf_b; // Buffer copy of compare B.
   logic [15:0] act_a; // Active compare A.
   logic [15:0] act_b; // Active compare B.
   logic [15:0] capture_value; // Capture word, usable as top.
   logic [15:0] count_value; // Counter.
   logic count_up; // Direction in dual-slope modes.
   logic [2:0] flags; // Sticky match and overflow flags.
   logic [9:0] presc; // Free-running prescaler.
   logic oc_a; // Waveform state of channel A.
   logic oc_b; // Waveform state of channel B.

   tco_wgm_t wave_gen_mode; // Combined four-bit mode.
   tco_om_t chan_a_output_mode; // Channel A field.
   tco_om_t chan_b_output_mode; // Channel B field.
   tco_class_e wclass; // Class of the current mode.
   logic [15:0] top; // Current top value.
   logic tick; // Timer tick, one cycle wide.
   logic at_top_evt; // Tick at top while counting up.
   logic wrap_evt; // Tick where single slope wraps to bottom.
   logic bottom_evt; // Tick at bottom in dual slope.
   logic reload; // Moment to copy buffers into active.
   logic ovf_evt; // Overflow flag event.
   logic match_a; // Tick with counter equal to compare A.
   logic match_b; // Tick with counter equal to compare B.
   logic conn_a; // Pin A taken over by the waveform.
   logic conn_b; // Pin B taken over by the waveform.
   logic acc; // Bus access taken this cycle.
   logic [15:0] next_count; // Counter value after a tick.

   // Decode the class of a waveform mode.
   function automatic tco_class_e mode_class(input tco_wgm_t m);
      case (m)
         4'h5, 4'h6, 4'h7, 4'hE, 4'hF: mode_class = TCO_FAST_PWM;
         4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: mode_class = TCO_DUAL_PWM;
         default: mode_class = TCO_NON_PWM;
      endcase
   endfunction

   // Next waveform state of one channel at a timer tick.
   function automatic logic next_wave(input tco_om_t om, input tco_class_e c, input logic cur,
                                      input logic match, input logic up, input logic wrap,
                                      input logic tgl_ok, input logic [15:0] cmp,
                                      input logic [15:0] tp);
      next_wave = cur;
      case (c)
         TCO_NON_PWM: begin
            if (match) begin
               next_wave = (om == 2'h1) ? ~cur : om[0];
            end
         end
         TCO_FAST_PWM: begin
            if (om[1]) begin
               if (wrap) begin
                  next_wave = ~om[0];
               end else if (match && cmp != tp) begin
                  next_wave = om[0];
               end
            end else if (tgl_ok && match) begin
               next_wave = ~cur;
            end
         end
         TCO_DUAL_PWM: begin
            if (om[1]) begin
               if (cmp == `TCO_BOTTOM) begin
                  next_wave = om[0];
               end else if (cmp == tp) begin
                  next_wave = ~om[0];
               end else if (match) begin
                  next_wave = up ? om[0] : ~om[0];
               end
            end else if (tgl_ok && match) begin
               next_wave = ~cur;
            end
         end
         default: next_wave = cur;
      endcase
   endfunction

   assign chan_a_output_mode = ctrl_a[`TCO_CHA_MODE_HI:`TCO_CHA_MODE_LO];
   assign chan_b_output_mode = ctrl_a[`TCO_CHB_MODE_HI:`TCO_CHB_MODE_LO];
   assign wave_gen_mode = {ctrl_b[`TCO_WGM_HIGH_HI:`TCO_WGM_HIGH_LO], ctrl_a[`TCO_WGM_LOW_HI:`TCO_WGM_LOW_LO]};
   assign wclass = mode_class(wave_gen_mode);
   assign acc = (avs_read || avs_write) && avs_waitrequest;

   // Top value from the mode; fixed tops, compare A or the capture word.
   always_comb begin
      case (wave_gen_mode)
         4'h1, 4'h5: top = `TCO_TOP8;
         4'h2, 4'h6: top = `TCO_TOP9;
         4'h3, 4'h7: top = `TCO_TOP10;
         4'h4, 4'h9, 4'hB, 4'hF: top = act_a;
         4'h8, 4'hA, 4'hC, 4'hE: top = capture_value;
         default: top = `TCO_MAX;
      endcase
   end

   // Tick from the clock select; external sources are not wired here, so they stop the counter.
   always_comb begin
      case (ctrl_b[`TCO_CLKSEL_HI:`TCO_CLKSEL_LO])
         3'h1: tick = 1'b1;
         3'h2: tick = &presc[2:0];
         3'h3: tick = &presc[5:0];
         3'h4: tick = &presc[7:0];
         3'h5: tick = &presc;
         default: tick = 1'b0;
      endcase
   end

   // Events derived at a tick.
   assign at_top_evt = tick && count_up && count_value == top;
   assign wrap_evt = tick && wclass != TCO_DUAL_PWM && count_value == top;
   assign bottom_evt = tick && wclass == TCO_DUAL_PWM && !count_up && count_value == `TCO_BOTTOM;
   assign match_a = tick && count_value == act_a;
   assign match_b = tick && count_value == act_b;

   always_comb begin
      case (wave_gen_mode)
         4'h1, 4'h2, 4'h3, 4'hA, 4'hB: reload = at_top_evt;
         4'h8, 4'h9: reload = bottom_evt;
         4'h5, 4'h6, 4'h7, 4'hE, 4'hF: reload = wrap_evt;
         default: reload = 1'b0;
      endcase
   end

   // overflow at bottom, top or max
   always_comb begin
      case (wclass)
         TCO_DUAL_PWM: ovf_evt = bottom_evt;
         TCO_FAST_PWM: ovf_evt = wrap_evt;
         default: ovf_evt = tick && count_value == `TCO_MAX;
      endcase
   end

   // Counter step; dual slope turns at top and at bottom.
   always_comb begin
      if (wclass == TCO_DUAL_PWM) begin
         if (count_up) begin
            next_count = (count_value == top) ? count_value - 16'h0001 : count_value + 16'h0001;
         end else begin
            next_count = (count_value == `TCO_BOTTOM) ? count_value + 16'h0001 : count_value - 16'h0001;
         end
      end else begin
         next_count = (count_value == top) ? `TCO_BOTTOM : count_value + 16'h0001;
      end
   end

   // Prescaler runs on every rising edge.
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         presc <= 10'h000;
      end else begin
         presc <= presc + 10'h001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         count_value <= `TCO_RST_WORD16;
         count_up <= 1'b1;
      end else if (acc && avs_write && avs_address == `TCO_OFS_COUNT) begin
         // A software write beats the tick.
         count_value <= avs_writedata[15:0];
      end else if (tick) begin
         count_value <= next_count;
         if (wclass != TCO_DUAL_PWM) begin
            count_up <= 1'b1;
         end else if (count_up && count_value == top) begin
            count_up <= 1'b0;
         end else if (!count_up && count_value == `TCO_BOTTOM) begin
            count_up <= 1'b1;
         end
      end
   end

   // Control registers; bits 3:2 of the first stay zero.
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ctrl_a <= `TCO_RST_CTRL;
         ctrl_b <= 5'h00;
      end else if (acc && avs_write) begin
         if (avs_address == `TCO_OFS_CTRL_A) begin
            ctrl_a <= {avs_writedata[7:4], 2'h0, avs_writedata[1:0]};
         end
         if (avs_address == `TCO_OFS_CTRL_B) begin
            ctrl_b <= avs_writedata[4:0];
         end
      end
   end

   // Compare buffers, active compares and capture word.
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         buf_a <= `TCO_RST_WORD16;
         buf_b <= `TCO_RST_WORD16;
         act_a <= `TCO_RST_WORD16;
         act_b <= `TCO_RST_WORD16;
         capture_value <= `TCO_RST_WORD16;
      end else begin
         if (acc && avs_write && avs_address == `TCO_OFS_CMP_A) begin
            buf_a <= avs_writedata[15:0];
         end
         if (acc && avs_write && avs_address == `TCO_OFS_CMP_B) begin
            buf_b <= avs_writedata[15:0];
         end
         if (acc && avs_write && avs_address == `TCO_OFS_CAPTURE) begin
            capture_value <= avs_writedata[15:0];
         end
         if (wclass == TCO_NON_PWM) begin
            act_a <= buf_a;
            act_b <= buf_b;
         end else if (reload) begin
            act_a <= buf_a;
            act_b <= buf_b;
         end
      end
   end

   // Sticky flags; write one to clear, and a new event wins over the clear.
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         flags <= 3'h0;
      end else begin
         if (acc && avs_write && avs_address == `TCO_OFS_STATUS) begin
            flags <= (flags & ~avs_writedata[2:0]) | {ovf_evt, match_b, match_a};
         end else begin
            flags <= flags | {ovf_evt, match_b, match_a};
         end
      end
   end

   // Waveform state of both channels.
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         oc_a <= 1'b0;
         oc_b <= 1'b0;
      end else if (tick) begin
         oc_a <= next_wave(chan_a_output_mode, wclass, oc_a, match_a, count_up, wrap_evt,
                           wave_gen_mode == 4'hE || wave_gen_mode == 4'hF
                           || wave_gen_mode == 4'h9 || wave_gen_mode == 4'hB
                           || wclass == TCO_NON_PWM, act_a, top);
         oc_b <= next_wave(chan_b_output_mode, wclass, oc_b, match_b, count_up, wrap_evt,
                           wclass == TCO_NON_PWM, act_b, top);
      end
   end

   always_comb begin
      conn_a = |chan_a_output_mode;
      conn_b = |chan_b_output_mode;
      if (wclass != TCO_NON_PWM && chan_a_output_mode == 2'h1) begin
         conn_a = (wave_gen_mode == 4'hE || wave_gen_mode == 4'hF
                   || wave_gen_mode == 4'h9 || wave_gen_mode == 4'hB);
      end
      if (wclass != TCO_NON_PWM && chan_b_output_mode == 2'h1) begin
         conn_b = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         compare_out_a <= 1'b0;
         compare_out_b <= 1'b0;
         compare_out_a_oe <= 1'b0;
         compare_out_b_oe <= 1'b0;
      end else begin
         compare_out_a <= conn_a ? oc_a : port_data_a;
         compare_out_b <= conn_b ? oc_b : port_data_b;
         compare_out_a_oe <= port_dir_a;
         compare_out_b_oe <= port_dir_b;
      end
   end

   // Bus answer: waitrequest drops for one cycle, one edge after the request appears.
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end else begin
         avs_waitrequest <= !acc;
         if (acc && avs_read) begin
            case (avs_address)
               `TCO_OFS_CTRL_A: avs_readdata <= {24'h000000, ctrl_a};
               `TCO_OFS_CTRL_B: avs_readdata <= {27'h0, ctrl_b};
               `TCO_OFS_CMP_A: avs_readdata <= {16'h0000, buf_a};
               `TCO_OFS_CMP_B: avs_readdata <= {16'h0000, buf_b};
               `TCO_OFS_CAPTURE: avs_readdata <= {16'h0000, capture_value};
               `TCO_OFS_COUNT: avs_readdata <= {16'h0000, count_value};
               `TCO_OFS_STATUS: avs_readdata <= {29'h0, flags};
               // Unmapped words read as zero.
               default: avs_readdata <= 32'h00000000;
            endcase
         end
      end
   end

   wait_pulse_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      acc |=> !avs_waitrequest ##1 avs_waitrequest) else $error("waitrequest not a one-cycle answer");

   flag_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (tick && count_value == act_a) |=> flags[0]) else $error("match flag A not set");

   buf_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (wclass != TCO_NON_PWM && !reload && $stable(wave_gen_mode)) |=> $stable(act_a))
      else $error("active compare A changed outside reload");

   pfc_update_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (bottom_evt && wave_gen_mode == 4'h8) |=> act_a == $past(buf_a))
      else $error("compare A not reloaded at bottom");

   ovf_bottom_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (wclass == TCO_DUAL_PWM && tick && !count_up && count_value == 16'h0000) |=> flags[2])
      else $error("overflow flag missed at bottom");

   ctrl_zero_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      ctrl_a[3:2] == 2'h0) else $error("reserved control bits nonzero");

   disc_pin_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      chan_a_output_mode == 2'h0 |=> compare_out_a == $past(port_data_a))
      else $error("pin A not under port control");

   nonpwm_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (wclass == TCO_NON_PWM && chan_a_output_mode == 2'h3 && match_a) |=> oc_a ##1 compare_out_a)
      else $error("non-PWM set on match failed");

   fast_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (wclass == TCO_FAST_PWM && chan_a_output_mode == 2'h2 && match_a && act_a != top && !wrap_evt)
      |=> !oc_a) else $error("fast PWM clear on match failed");

endmodule

`default_nettype wire

/* tb/tco_board.sv */
`timescale 1ns/1ps
`default_nettype none

// Board around the two compare pins; each pin has a pull-up, so a pin nobody drives reads high.
module tco_board (
   input wire logic out_a, // Level from the pin A driver.
   input wire logic oe_a, // Pin A driver enable.
   input wire logic out_b, // Level from the pin B driver.
   input wire logic oe_b, // Pin B driver enable.
   output logic pin_a, // Resolved level on pin A.
   output logic pin_b // Resolved level on pin B.
);
   // driver needs direction.
   // A waveform with its driver off never reaches the board, so the pull-up wins.
   assign pin_a = oe_a ? out_a : 1'b1;
   assign pin_b = oe_b ? out_b : 1'b1;
endmodule

`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tco_defines.svh"

module testbench
   import tco_pkg::*;
;
   logic sys_clk = 1'b0; // System clock.
   logic nrst = 1'b0; // Reset, active low.
   logic [7:0] avs_address = 8'h00; // Bus address.
   logic avs_read = 1'b0; // Bus read.
   logic avs_write = 1'b0; // Bus write.
   logic [31:0] avs_writedata = 32'h00000000; // Bus write data.
   logic [31:0] avs_readdata; // Bus read data.
   logic avs_waitrequest; // Bus stall.
   logic port_data_a = 1'b0; // Port value A.
   logic port_dir_a = 1'b0; // Direction A.
   logic port_data_b = 1'b0; // Port value B.
   logic port_dir_b = 1'b0; // Direction B.
   logic out_a, oe_a, out_b, oe_b; // Pin drivers.
   logic pin_a, pin_b; // Board levels.
   int fails = 0; // Mismatches.
   int compares = 0; // Comparisons.
   int ha, hb, ta, tb; // High and toggle counts.

   // The clock runs at 40 MHz.
   always #12.5 sys_clk = ~sys_clk;

   tco_top u_dut (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .port_data_a(port_data_a), .port_dir_a(port_dir_a),
      .port_data_b(port_data_b), .port_dir_b(port_dir_b), .compare_out_a(out_a),
      .compare_out_a_oe(oe_a), .compare_out_b(out_b), .compare_out_b_oe(oe_b));
   tco_board u_board (.out_a(out_a), .oe_a(oe_a), .out_b(out_b), .oe_b(oe_b), .pin_a(pin_a), .pin_b(pin_b));

   // Prints the counts and the verdict, then ends the run.
   task close_out();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Exact comparison of a value seen on the ports.
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask

   // Counts over a window carry a phase error, hence the tolerance.
   task near(input int got, input int exp, input int tol, input string what);
      compares++;
      if (got < exp - tol || got > exp + tol) begin
         fails++;
         $display("ERROR %0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask

   // One write; the request stands until waitrequest is seen low.
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask

   // One read; data are taken at the edge where waitrequest is low.
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
   endtask

   // Loads both compares and both controls, then restarts the count from zero.
   task cfg(input logic [7:0] ca, input logic [7:0] cb, input logic [15:0] va, input logic [15:0] vb);
      wr(`TCO_OFS_CMP_A, {16'h0000, va});
      wr(`TCO_OFS_CMP_B, {16'h0000, vb});
      wr(`TCO_OFS_CTRL_A, {24'h000000, ca});
      wr(`TCO_OFS_CTRL_B, {24'h000000, cb});
      wr(`TCO_OFS_COUNT, 32'h00000000);
   endtask

   // Counts high cycles and level changes on both pins over n cycles.
   task meas(input int n);
      logic pa, pb;
      ha = 0;
      hb = 0;
      ta = 0;
      tb = 0;
      @(posedge sys_clk);
      pa = pin_a;
      pb = pin_b;
      repeat (n) begin
         @(posedge sys_clk);
         ha += (pin_a === 1'b1);
         hb += (pin_b === 1'b1);
         ta += (pin_a !== pa);
         tb += (pin_b !== pb);
         pa = pin_a;
         pb = pin_b;
      end
   endtask

   // High cycles of an 8-bit single-slope wave: high from bottom up to the match.
   function automatic int fast_high(input int c, input int n, input bit inv);
      int h;
      h = n * (c + 1) / 256;
      return inv ? n - h : h;
   endfunction

   // High cycles of an 8-bit dual-slope wave: high below the compare value.
   function automatic int dual_high(input int c, input int n, input bit inv);
      int h;
      h = n * 2 * c / 510;
      return inv ? n - h : h;
   endfunction

   // Watchdog sized well above the whole sequence.
   initial begin
      #(100000 * 25);
      fails++;
      close_out();
   end

   // Main sequence.
   initial begin
      logic [31:0] r;
      int c, d;
      void'($urandom(32'hEA6B59FB));
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      rd(`TCO_OFS_CTRL_A, r);
      chk(r, 32'h00000000, "ctrl a reset");
      wr(`TCO_OFS_CTRL_A, 32'h000000FF);
      rd(`TCO_OFS_CTRL_A, r);
      chk(r, 32'h000000F3, "ctrl a reserved");
      rd(8'hA0, r);
      chk(r, 32'h00000000, "unmapped read");
      wr(`TCO_OFS_CTRL_A, 32'h00000000);
      // Disconnected pins follow the port; drivers follow the direction bits.
      repeat (16) begin
         @(posedge sys_clk);
         port_data_a <= 1'($urandom);
         port_data_b <= 1'($urandom);
         port_dir_a <= 1'($urandom);
         port_dir_b <= 1'($urandom);
         repeat (3) @(posedge sys_clk);
         chk({30'h0, out_a, out_b}, {30'h0, port_data_a, port_data_b}, "port path");
         chk({30'h0, oe_a, oe_b}, {30'h0, port_dir_a, port_dir_b}, "driver enable");
      end
      port_dir_a <= 1'b1;
      port_dir_b <= 1'b1;
      // Clear-on-match mode with toggle, at full rate and divided by 8.
      cfg(8'h50, 8'h09, 16'h0009, 16'h0009);
      repeat (50) @(posedge sys_clk);
      meas(400);
      near(ta, 40, 2, "toggle a");
      near(tb, 40, 2, "toggle b");
      wr(`TCO_OFS_CTRL_B, 32'h0000000A);
      meas(1600);
      near(ta, 20, 2, "toggle prescaled");
      // Clear first, then set, on match; the port is held at the opposite level.
      // Clearing first makes the set check able to fail, as the toggles may leave the state high.
      port_data_a <= 1'b1;
      port_data_b <= 1'b1;
      cfg(8'hA0, 8'h09, 16'h0009, 16'h0009);
      repeat (40) @(posedge sys_clk);
      chk({30'h0, pin_a, pin_b}, 32'h00000000, "clear on match");
      port_data_a <= 1'b0;
      port_data_b <= 1'b0;
      wr(`TCO_OFS_CTRL_A, 32'h000000F0);
      repeat (40) @(posedge sys_clk);
      chk({30'h0, pin_a, pin_b}, 32'h00000003, "set on match");
      wr(`TCO_OFS_CTRL_B, 32'h00000008);
      rd(`TCO_OFS_STATUS, r);
      chk({30'h0, r[1:0]}, 32'h00000003, "match flags");
      wr(`TCO_OFS_STATUS, 32'h00000003);
      rd(`TCO_OFS_STATUS, r);
      chk({30'h0, r[1:0]}, 32'h00000000, "flags cleared");
      // Fast 8-bit PWM, A non-inverting and B inverting, random duty.
      repeat (3) begin
         c = $urandom_range(239, 16);
         d = $urandom_range(239, 16);
         cfg(8'hB1, 8'h09, 16'(c), 16'(d));
         repeat (600) @(posedge sys_clk);
         meas(1024);
         near(ha, fast_high(c, 1024, 1'b0), 8, "fast duty a");
         near(hb, fast_high(d, 1024, 1'b1), 8, "fast duty b");
      end
      cfg(8'hB1, 8'h09, 16'h00FF, 16'h00FF);
      repeat (600) @(posedge sys_clk);
      meas(1024);
      near(ha, 1024, 0, "top match ignored a");
      near(hb, 0, 0, "top match ignored b");
      // Toggle code in fast PWM: only modes 14 and 15, only channel A.
      port_data_a <= 1'b1;
      port_data_b <= 1'b0;
      cfg(8'h51, 8'h09, 16'h0009, 16'h0009);
      repeat (50) @(posedge sys_clk);
      meas(300);
      near(ha, 300, 0, "fast toggle off");
      wr(`TCO_OFS_CAPTURE, 32'h00000009);
      cfg(8'h52, 8'h19, 16'h0005, 16'h0005);
      repeat (50) @(posedge sys_clk);
      meas(300);
      near(ta, 30, 2, "fast toggle a");
      near(hb, 0, 0, "fast toggle b off");
      // Phase-correct 8-bit PWM, random duty.
      repeat (3) begin
         c = $urandom_range(239, 16);
         d = $urandom_range(239, 16);
         cfg(8'hB1, 8'h01, 16'(c), 16'(d));
         repeat (600) @(posedge sys_clk);
         meas(1020);
         near(ha, dual_high(c, 1020, 1'b0), 8, "dual duty a");
         near(hb, dual_high(d, 1020, 1'b1), 8, "dual duty b");
      end
      cfg(8'hA1, 8'h01, 16'h0000, 16'h00FF);
      wr(`TCO_OFS_STATUS, 32'h00000007);
      repeat (600) @(posedge sys_clk);
      meas(1020);
      near(ha, 0, 0, "compare at bottom");
      near(hb, 1020, 0, "compare at top");
      wr(`TCO_OFS_CTRL_B, 32'h00000000);
      rd(`TCO_OFS_STATUS, r);
      chk({31'h0, r[2]}, 32'h00000001, "overflow at bottom");
      // Toggle code in dual slope: only modes 9 and 11, only channel A.
      cfg(8'h51, 8'h01, 16'h0014, 16'h0014);
      repeat (50) @(posedge sys_clk);
      meas(400);
      near(ta, 0, 0, "dual toggle off");
      cfg(8'h53, 8'h11, 16'h0014, 16'h0014);
      repeat (100) @(posedge sys_clk);
      meas(400);
      near(ta, 10, 2, "dual toggle a");
      near(ha, 200, 25, "half duty");
      near(tb, 0, 0, "dual toggle b off");
      // Phase-and-frequency-correct PWM, capture word 20 as top: a period of 40 cycles.
      c = $urandom_range(18, 2);
      d = $urandom_range(18, 2);
      wr(`TCO_OFS_CAPTURE, 32'h00000014);
      cfg(8'hB0, 8'h11, 16'(c), 16'(d));
      repeat (100) @(posedge sys_clk);
      meas(400);
      near(ha, 20 * c, 4, "pfc duty a");
      near(hb, 400 - 20 * d, 4, "pfc duty b");
      close_out();
   end
endmodule

`default_nettype wire
